// [hw/lscp_defines.svh]
// constants of the linear sensor command port
`ifndef LSCP_DEFINES_SVH
`define LSCP_DEFINES_SVH
`define LSCP_CMD_RESET 8'h1B
`define LSCP_CMD_START 8'h08
`define LSCP_CMD_CAPTURE 8'h10
`define LSCP_CMD_DUMP 8'h02
`define LSCP_CMD_CANCEL 8'h19
`define LSCP_CMD_CAP_DUMP 8'h12
`define LSCP_CMD_CAP_DUMP_START 8'h16
`define LSCP_OP_STORE 3'h2
`define LSCP_OP_FETCH 3'h3
`define LSCP_START_DLY 5'h14
`define LSCP_DUMP_DLY 5'h14
`define LSCP_FETCH_DLY 5'h04
`define LSCP_FRAME_LAST 4'h9
`define LSCP_FETCH_LAST 4'h7
`define LSCP_PIX_LAST 7'h65
`define LSCP_ZONE_PIX 7'h22
`define LSCP_GAIN_ADDR 5'h00
`define LSCP_OFFS_ADDR 5'h03
`define LSCP_RX_STOP 4'h9
`endif

// [hw/lscp_pkg.sv]
// types shared by the linear sensor command port
`default_nettype none
package lscp_pkg;
  typedef struct packed {
    logic brk;
    logic valid;
    logic [7:0] data;
  } lscp_rx_t;
  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001,
    TX_FWAIT = 5'b00010,
    TX_FSEND = 5'b00100,
    TX_DWAIT = 5'b01000,
    TX_DSEND = 5'b10000
  } lscp_tx_t;
endpackage : lscp_pkg
`default_nettype wire

// [hw/lscp_rx.sv]
// serial byte receiver with break detection
`timescale 1ns/100ps
`default_nettype none
`include "lscp_defines.svh"
module lscp_rx (
  input wire logic clk, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic rise, // shift clock rising edge
  input wire logic din, // synchronised serial_in
  output var lscp_pkg::lscp_rx_t rx // byte or break, one-cycle pulses
);
  logic active_q;
  logic need_high_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;

  // frame: start 0, eight bits lsb first, stop 1; all-zero frame is a break
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      active_q <= 1'b0;
      need_high_q <= 1'b0;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      rx <= '0;
    end else begin
      rx.valid <= 1'b0;
      rx.brk <= 1'b0;
      if (rise) begin
        if (!active_q) begin
          // a held-low line must return high before a new start
          if (din) need_high_q <= 1'b0;
          else if (!need_high_q) begin
            active_q <= 1'b1;
            bit_q <= 4'h1;
          end
        end else if (bit_q == `LSCP_RX_STOP) begin
          active_q <= 1'b0;
          if (din) begin
            rx.valid <= 1'b1;
            rx.data <= sh_q;
          end else if (sh_q == 8'h00) begin
            rx.brk <= 1'b1;
            need_high_q <= 1'b1;
          end else need_high_q <= 1'b1;
        end else begin
          sh_q <= {din, sh_q[7:1]};
          bit_q <= bit_q + 4'h1;
        end
      end
    end
  end
endmodule : lscp_rx
`default_nettype wire

// [hw/lscp_top.sv]
// command interpreter of the linear sensor serial port
`timescale 1ns/100ps
`default_nettype none
`include "lscp_defines.svh"
module lscp_top #(
  parameter int PIX_W = 7 // pixel index width
) (
  input wire logic CLK, // 40 MHz system clock
  input wire logic RST_B, // async reset, active low
  input wire logic SCLK, // shift clock pin
  input wire logic SERIAL_IN, // serial_in pin
  input wire logic [7:0] ADC_DATA, // converted sample of PIXEL_SEL
  output logic SERIAL_OUT, // serial_out pin
  output logic [PIX_W-1:0] PIXEL_SEL, // pixel being converted
  output logic [7:0] ZONE_GAIN, // gain of current zone
  output logic [7:0] ZONE_OFFSET, // offset of current zone
  output logic INTEG_RUN, // integrators integrating
  output logic HOLD_VALID, // sample-holds carry values
  output logic CAPTURE_PULSE // integrator to hold transfer
);
  logic sclk_m_q, sclk_s_q, sclk_p_q, din_m_q, din_s_q;
  logic rise, fall;
  lscp_pkg::lscp_rx_t rx;
  lscp_pkg::lscp_tx_t st_q;
  logic expect_q;
  logic [4:0] addr_q;
  logic [7:0] reg_mem [32];
  logic pend_q;
  logic [4:0] scnt_q, dcnt_q;
  logic [3:0] bit_q;
  logic [8:0] sh_q;
  logic [1:0] zone;
  logic cmd_v, is_rst, is_cancel, do_cap, do_dump, do_start, do_store;
  logic do_fetch, known;

  // two-stage synchronisers; stage two is looked at, plus a third shift clock flop for edge detection
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      // idle-high reset level, so a parked clock gives no false rise
      sclk_m_q <= 1'b1;
      sclk_s_q <= 1'b1;
      sclk_p_q <= 1'b1;
      din_m_q <= 1'b1;
      din_s_q <= 1'b1;
    end else begin
      sclk_m_q <= SCLK;
      sclk_s_q <= sclk_m_q;
      sclk_p_q <= sclk_s_q;
      din_m_q <= SERIAL_IN;
      din_s_q <= din_m_q;
    end
  end
  assign rise = sclk_s_q & ~sclk_p_q;
  assign fall = ~sclk_s_q & sclk_p_q;

  lscp_rx u_rx (
    .clk(CLK),
    .rst_b(RST_B),
    .rise(rise),
    .din(din_s_q),
    .rx(rx)
  );

  // command decode; a byte after a store opcode is data, not a command
  assign cmd_v = rx.valid & ~expect_q;
  assign is_rst = cmd_v && rx.data == `LSCP_CMD_RESET;
  assign is_cancel = cmd_v && rx.data == `LSCP_CMD_CANCEL;
  assign do_cap = cmd_v && (rx.data == `LSCP_CMD_CAPTURE ||
    rx.data == `LSCP_CMD_CAP_DUMP ||
    rx.data == `LSCP_CMD_CAP_DUMP_START);
  assign do_dump = cmd_v && (rx.data == `LSCP_CMD_DUMP ||
    rx.data == `LSCP_CMD_CAP_DUMP ||
    rx.data == `LSCP_CMD_CAP_DUMP_START);
  assign do_start = cmd_v && (rx.data == `LSCP_CMD_START ||
    rx.data == `LSCP_CMD_CAP_DUMP_START);
  assign do_store = cmd_v && rx.data[7:5] == `LSCP_OP_STORE;
  assign do_fetch = cmd_v && rx.data[7:5] == `LSCP_OP_FETCH;
  assign known = is_rst | is_cancel | do_cap | do_dump | do_start |
    do_store | do_fetch;

  // byte tracker: a break drops a pending data byte; a main reset byte then is stored as data
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      expect_q <= 1'b0;
      addr_q <= 5'h00;
    end else if (rx.brk || is_rst) begin
      expect_q <= 1'b0;
    end else if (do_store) begin
      expect_q <= 1'b1;
      addr_q <= rx.data[4:0];
    end else if (do_fetch) begin
      addr_q <= rx.data[4:0];
    end else if (rx.valid) begin
      expect_q <= 1'b0;
    end
  end

  // register file; contents survive main reset so calibration is kept
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < 32; i++) reg_mem[i] <= 8'h00;
    end else if (rx.valid && expect_q) begin
      reg_mem[addr_q] <= rx.data;
    end
  end

  // zone of the pixel under conversion picks its gain and offset
  assign zone = (PIXEL_SEL < `LSCP_ZONE_PIX) ? 2'h0 :
    (PIXEL_SEL < 7'(2 * `LSCP_ZONE_PIX)) ? 2'h1 : 2'h2;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ZONE_GAIN <= 8'h00;
      ZONE_OFFSET <= 8'h00;
    end else begin
      ZONE_GAIN <= reg_mem[`LSCP_GAIN_ADDR + 5'(zone)];
      ZONE_OFFSET <= reg_mem[`LSCP_OFFS_ADDR + 5'(zone)];
    end
  end

  // integration state; start waits out the auto-zero cycle on rising edges
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      INTEG_RUN <= 1'b0;
      HOLD_VALID <= 1'b0;
      CAPTURE_PULSE <= 1'b0;
      pend_q <= 1'b0;
      scnt_q <= 5'h00;
    end else begin
      CAPTURE_PULSE <= do_cap;
      if (is_rst || is_cancel) begin
        INTEG_RUN <= 1'b0;
        HOLD_VALID <= 1'b0;
        pend_q <= 1'b0;
      end else begin
        if (do_cap) begin
          HOLD_VALID <= 1'b1;
          INTEG_RUN <= 1'b0;
        end
        if (do_start) begin
          pend_q <= 1'b1;
          scnt_q <= `LSCP_START_DLY - 5'h01;
        end else if (pend_q && rise) begin
          if (scnt_q == 5'h00) begin
            pend_q <= 1'b0;
            INTEG_RUN <= 1'b1;
          end else scnt_q <= scnt_q - 5'h01;
        end
      end
    end
  end

  // output sequencer; serial_out moves only on falling shift clock edges
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_q <= lscp_pkg::TX_IDLE;
      dcnt_q <= 5'h00;
      bit_q <= 4'h0;
      sh_q <= 9'h1FF;
      SERIAL_OUT <= 1'b1;
      PIXEL_SEL <= '0;
    end else if (is_rst || is_cancel) begin
      st_q <= lscp_pkg::TX_IDLE;
      PIXEL_SEL <= '0;
    end else if (do_dump) begin
      st_q <= lscp_pkg::TX_DWAIT;
      dcnt_q <= `LSCP_DUMP_DLY - 5'h01;
      PIXEL_SEL <= '0;
      bit_q <= 4'h0;
    end else if (do_fetch) begin
      st_q <= lscp_pkg::TX_FWAIT;
      dcnt_q <= `LSCP_FETCH_DLY - 5'h01;
      sh_q <= {1'b1, reg_mem[rx.data[4:0]]};
      bit_q <= 4'h0;
    end else if (fall) begin
      case (st_q)
        lscp_pkg::TX_IDLE: SERIAL_OUT <= 1'b1;
        lscp_pkg::TX_FWAIT, lscp_pkg::TX_DWAIT: begin
          if (dcnt_q == 5'h00)
            st_q <= (st_q == lscp_pkg::TX_FWAIT) ? lscp_pkg::TX_FSEND
                                                 : lscp_pkg::TX_DSEND;
          else dcnt_q <= dcnt_q - 5'h01;
        end
        lscp_pkg::TX_FSEND: begin
          SERIAL_OUT <= sh_q[0];
          sh_q <= {1'b1, sh_q[8:1]};
          bit_q <= bit_q + 4'h1;
          if (bit_q == `LSCP_FETCH_LAST) st_q <= lscp_pkg::TX_IDLE;
        end
        lscp_pkg::TX_DSEND: begin
          if (bit_q == 4'h0) begin
            SERIAL_OUT <= 1'b0;
            sh_q <= {1'b1, ADC_DATA};
          end else begin
            SERIAL_OUT <= sh_q[0];
            sh_q <= {1'b1, sh_q[8:1]};
          end
          if (bit_q == `LSCP_FRAME_LAST) begin
            bit_q <= 4'h0;
            if (PIXEL_SEL == `LSCP_PIX_LAST) st_q <= lscp_pkg::TX_IDLE;
            else PIXEL_SEL <= PIXEL_SEL + 7'h01;
          end else bit_q <= bit_q + 4'h1;
        end
        default: st_q <= lscp_pkg::TX_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  a_resync_clears: assert property (rx.brk |=> !expect_q)
    else $error("break did not clear byte tracker");
  a_store_writes: assert property (rx.valid && expect_q |=>
    reg_mem[$past(addr_q)] == $past(rx.data))
    else $error("stored byte missing");
  a_reset_aborts: assert property (is_rst |=> st_q == lscp_pkg::TX_IDLE
    && !INTEG_RUN && !HOLD_VALID && !pend_q)
    else $error("main reset left activity");
  a_cancel_aborts: assert property (is_cancel |=>
    st_q == lscp_pkg::TX_IDLE && !INTEG_RUN && !HOLD_VALID)
    else $error("cancel left activity");
  a_capture_holds: assert property (do_cap && !is_rst |=>
    HOLD_VALID && !INTEG_RUN && CAPTURE_PULSE)
    else $error("capture did not hold");
  a_start_deferred: assert property ($rose(INTEG_RUN) |->
    $past(pend_q) && $past(scnt_q) == 5'h00 && $past(rise))
    else $error("integration started early");
  a_frame_start: assert property (st_q == lscp_pkg::TX_DSEND && fall &&
    bit_q == 4'h0 && !cmd_v |=> !SERIAL_OUT)
    else $error("missing start bit");
  a_frame_stop: assert property (st_q == lscp_pkg::TX_DSEND && fall &&
    bit_q == `LSCP_FRAME_LAST && !cmd_v |=> SERIAL_OUT)
    else $error("missing stop bit");
  a_pixel_order: assert property ($changed(PIXEL_SEL) &&
    PIXEL_SEL != '0 |-> PIXEL_SEL == $past(PIXEL_SEL) + 7'h01)
    else $error("pixel order broken");
  a_out_on_fall: assert property ($changed(SERIAL_OUT) |-> $past(fall))
    else $error("serial_out moved off a falling edge");
  a_unknown_ignored: assert property (cmd_v && !known |=>
    $stable(INTEG_RUN) && $stable(HOLD_VALID) && $stable(st_q))
    else $error("unknown command acted");

  c_dump_done: cover property (st_q == lscp_pkg::TX_DSEND &&
    PIXEL_SEL == `LSCP_PIX_LAST ##1 st_q == lscp_pkg::TX_IDLE);
  c_fetch: cover property (st_q == lscp_pkg::TX_FSEND);
  c_break: cover property (rx.brk);
  c_integ: cover property ($rose(INTEG_RUN));
endmodule : lscp_top
`default_nettype wire

// [sim/lscp_ctrl_model.sv]
// serial controller model: shift clock, serial_in and serial_out sampling
`timescale 1ns/100ps
`default_nettype none
module lscp_ctrl_model (
  output logic sclk, // shift clock, stands high between frames
  output logic serial_in, // idle high
  input wire logic serial_out // output of the device
);
  logic q[$]; // serial_out samples, one per shift clock
  // line idle and clock parked high until the first tick
  initial begin
    sclk = 1'b1;
    serial_in = 1'b1;
  end
  // new bit after the fall, device samples at the rise
  task automatic tick(input logic b);
    sclk = 1'b0;
    serial_in = b;
    #100;
    sclk = 1'b1;
    #100;
    q.push_back(serial_out); // late in the bit so the output has settled
  endtask : tick
  // idle clocks with the line high, also the gap after a command
  task automatic idle(input int n);
    repeat (n) tick(1'b1);
  endtask : idle
  // start, eight bits lsb first, stop; stop low with zero data is a break
  task automatic frame(input logic [7:0] b, input logic stp);
    tick(1'b0);
    for (int i = 0; i < 8; i++) tick(b[i]);
    tick(stp);
    q.delete();
  endtask : frame
endmodule : lscp_ctrl_model
`default_nettype wire

// [sim/testbench.sv]
// self-checking bench of the linear sensor command port
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk;
  logic rst_b;
  logic [7:0] adc;
  wire logic sclk;
  wire logic serial_in;
  wire logic serial_out;
  wire logic [6:0] pix;
  wire logic [7:0] gain;
  wire logic [7:0] offs;
  wire logic integ;
  wire logic hold;
  wire logic cap;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int caps = 0;

  lscp_top DUT (
    .CLK(clk),
    .RST_B(rst_b),
    .SCLK(sclk),
    .SERIAL_IN(serial_in),
    .ADC_DATA(adc),
    .SERIAL_OUT(serial_out),
    .PIXEL_SEL(pix),
    .ZONE_GAIN(gain),
    .ZONE_OFFSET(offs),
    .INTEG_RUN(integ),
    .HOLD_VALID(hold),
    .CAPTURE_PULSE(cap)
  );
  lscp_ctrl_model ctrl (
    .sclk(sclk),
    .serial_in(serial_in),
    .serial_out(serial_out)
  );

  // 40 MHz system clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // converter stand-in: every pixel gets its own code
  always @(negedge clk) adc <= {1'b0, pix} ^ 8'hA5;

  // capture pulse count and a run limit well above the expected length;
  // looked at mid-cycle so the registered pulse has settled
  always @(negedge clk) begin
    cycles++;
    if (cap === 1'b1) caps++;
    if (cycles == 60000) begin
      bad_count++;
      stop_test();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  function automatic logic [7:0] rv(input int a);
    return 8'h3C + 8'(a * 37);
  endfunction : rv

  // and of all serial_out samples since the last command
  function automatic logic q_high();
    logic r = 1'b1;
    foreach (ctrl.q[i]) r &= ctrl.q[i];
    return r;
  endfunction : q_high

  task automatic t_power();
    ctrl.idle(30);
    ctrl.frame(8'h00, 1'b0);
    ctrl.idle(8);
    ctrl.frame(8'h1B, 1'b1);
    ctrl.idle(30);
    ctrl.frame(8'h1B, 1'b1);
    ctrl.idle(8);
    ctrl.frame(8'h1B, 1'b1);
    ctrl.idle(8);
    chk({integ, hold, q_high()}, 3'b001);
  endtask : t_power

  // gain and offset of each zone written, then read back
  task automatic t_regs();
    logic [7:0] v;
    for (int a = 0; a < 6; a++) begin
      ctrl.frame({3'h2, 5'(a)}, 1'b1);
      ctrl.frame(rv(a), 1'b1);
      ctrl.idle(8);
    end
    for (int a = 0; a < 6; a++) begin
      ctrl.frame({3'h3, 5'(a)}, 1'b1);
      ctrl.idle(14);
      for (int i = 0; i < 8; i++) v[i] = ctrl.q[4 + i];
      chk({v, ctrl.q[12], ctrl.q[3]}, {rv(a), 2'b11});
    end
    chk({gain, offs}, {rv(0), rv(3)});
  endtask : t_regs

  task automatic t_start();
    ctrl.frame(8'h08, 1'b1);
    ctrl.idle(19);
    chk(integ, 1'h0);
    ctrl.idle(1);
    #100;
    chk(integ, 1'h1);
  endtask : t_start

  task automatic t_capture();
    int c0;
    c0 = caps;
    ctrl.frame(8'h10, 1'b1);
    ctrl.idle(8);
    chk({hold, integ, 6'(caps - c0)}, 8'h81);
  endtask : t_capture

  task automatic t_unknown();
    logic [7:0] codes [4] = '{8'h05, 8'h20, 8'h9C, 8'hFF};
    foreach (codes[i]) begin
      ctrl.frame(codes[i], 1'b1);
      ctrl.idle(30);
      chk({integ, hold, q_high(), gain}, {3'b011, rv(0)});
    end
  endtask : t_unknown

  // one full dump, every frame compared against the converter codes
  task automatic t_dump(input logic [7:0] c);
    int c0;
    logic [9:0] f;
    c0 = caps;
    ctrl.frame(c, 1'b1);
    ctrl.idle(420);
    chk({gain, offs}, {rv(1), rv(4)});
    chk(pix, 7'h28);
    ctrl.idle(624);
    chk({ctrl.q[19], ctrl.q[1040], ctrl.q[1043]}, 3'b111);
    for (int p = 0; p < 102; p++) begin
      for (int i = 0; i < 10; i++) f[i] = ctrl.q[20 + 10 * p + i];
      chk(f, {1'b1, 8'(p) ^ 8'hA5, 1'b0});
    end
    chk({hold, integ, 6'(caps - c0)},
      {1'b1, c == 8'h16, 6'(c != 8'h02)});
    chk({gain, offs}, {rv(2), rv(5)});
    chk(pix, 7'h65);
  endtask : t_dump

  // abort in mid-dump while integrating
  task automatic t_abort(input logic [7:0] c);
    ctrl.frame(8'h16, 1'b1);
    ctrl.idle(60);
    chk({integ, hold}, 2'b11);
    ctrl.frame(c, 1'b1);
    ctrl.idle(40);
    chk({integ, hold, q_high()}, 3'b001);
    chk(pix, 7'h00);
  endtask : t_abort

  // reset, then the scenarios in a controller-like order
  initial begin
    rst_b = 1'b0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    t_power();
    t_regs();
    t_start();
    t_capture();
    t_unknown();
    t_dump(8'h02);
    t_dump(8'h12);
    t_dump(8'h16);
    t_abort(8'h19);
    t_abort(8'h1B);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
